// >>> src/phylc_top.sv
// phylc_top: phy link control registers and the logic they steer
// assumes status inputs are synchronous to aclk and symbol strobes are
// one-cycle pulses from the receive decoder
// Operation
// RULE1 - fast an bit shortens negotiation timers
// RULE2 - select codes give 50, 75, 150 ms
// RULE3 - both partners use same fast an setup
// RULE4 - fast mode raises rx_dv on /J/ alone
// RULE5 - far-end drop disables transmit on link loss; code does so only in forced 100 (auto-negotiation off, 100 Mbps)
// RULE6 - fx enable bit, reset value from strap
// RULE7 - fast parallel detect set by auto-mdix modes
// RULE8 - extended full duplex against forced partner
// RULE9 - enhanced led lights only 100tx full duplex
// RULE10 - enhanced led suppresses activity blinking
// RULE11 - isolate mii on half 100tx or 10te
// RULE12 - optional symbol error report during idle
// RULE13 - odd nibble end extends tx_en as error
// RULE14 - rmii receive pair timing reference select
// RULE15 - software keeps reserved fields as reset
`timescale 1ns/1ps
module phylc_top
	import phylc_pkg::*;
#(
	parameter logic [LFI_W-1:0] P_LFI_50_CYC  = LFI_50_CYC,   // 50 ms
	parameter logic [LFI_W-1:0] P_LFI_75_CYC  = LFI_75_CYC,   // 75 ms
	parameter logic [LFI_W-1:0] P_LFI_150_CYC = LFI_150_CYC,  // 150 ms
	parameter logic [LFI_W-1:0] P_LFI_STD_CYC = LFI_STD_CYC   // standard
)(
	input  wire logic              aclk,            // 125 MHz clock
	input  wire logic              aresetn,         // sync reset, active low
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,    // write address
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [DATA_W-1:0] s_axi_wdata,     // write data
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,    // read address
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              strap_fx,        // fx strap level
	input  wire logic              link_up,         // link established
	input  wire logic              speed_100,       // 1 = 100 Mbps link
	input  wire logic              std_full_duplex, // standard duplex result
	input  wire logic              an_enabled,      // auto-negotiation on
	input  wire logic              partner_forced,  // partner forced 100tx
	input  wire logic              activity,        // tx or rx activity
	input  wire logic              lfi_start,       // start inhibit timer
	input  wire logic              sym_strobe,      // one received symbol
	input  wire logic              sym_j,           // symbol is /J/
	input  wire logic              sym_k,           // symbol is /K/
	input  wire logic              sym_end,         // end of stream or idle
	input  wire logic              sym_err,         // invalid symbol
	input  wire logic [1:0]        rmii_rxd_rec,    // pair on recovered clock
	input  wire logic [1:0]        rmii_rxd_ref,    // pair on reference clock
	input  wire logic              tx_tick,         // one per tx_clk cycle
	input  wire logic              tx_en_in,        // mac tx enable
	input  wire logic              tx_er_in,        // mac tx error
	output logic                   fast_an,         // fast an enable bit of control_one
	output logic                   lfi_expired,     // inhibit timer done
	output logic                   rx_dv,           // receive data valid
	output logic                   rx_er_idle,      // idle symbol error
	output logic                   tx_disable,      // transmitter off
	output logic                   fx_mode,         // fibre mode
	output logic                   fast_pd,         // fast parallel detect
	output logic                   full_duplex,     // resolved duplex
	output logic                   led_link,        // link led drive
	output logic                   mii_isolate,     // mii outputs isolated
	output logic [1:0]             rmii_rxd,        // selected rmii pair
	output logic                   tx_en_out,       // coder tx enable
	output logic                   tx_er_out        // coder tx error
);

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic              aw_got;       // write address held
		logic [ADDR_W-1:0] awaddr;
		logic              w_got;        // write data held
		logic [DATA_W-1:0] wdata;
		logic [3:0]        wstrb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
		logic [REG_W-1:0]  ctl1;         // control_one
		logic [REG_W-1:0]  ctl2;         // control_two
		phylc_rx_e         rx_st;        // start-of-stream tracking
		logic              rx_dv;
		logic              rx_er_idle;
		logic [LFI_W-1:0]  lfi_cnt;      // inhibit countdown
		logic              lfi_busy;
		logic              lfi_expired;
		logic              tx_disable;
		logic              full_duplex;
		logic              led_link;
		logic              mii_isolate;
		logic [1:0]        rmii_rxd;
	} phylc_state_s;

	phylc_state_s s_r;                   // current state
	phylc_state_s s_nxt;                 // next state
	logic         forced_100;            // forced 100 Mbps operation
	logic         fd_res;                // duplex after extension
	logic         do_write;              // both halves of a write held

	////////////////////////////////////////////////////////////////////////
	// helpers

	// address decode, shared by the read and write paths
	function automatic phylc_sel_e reg_sel(input logic [ADDR_W-1:0] a);
		if (a == ADR_CONTROL_ONE) begin
			return SEL_ONE;
		end else if (a == ADR_CONTROL_TWO) begin
			return SEL_TWO;
		end else begin
			return SEL_NONE;
		end
	endfunction : reg_sel

	// merge write data into a register under byte strobes and rw mask
	function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
		input logic [DATA_W-1:0] d, input logic [3:0] st,
		input logic [REG_W-1:0] m);
		logic [REG_W-1:0] v;
		v = old;
		if (st[0]) v[7:0]  = d[7:0];
		if (st[1]) v[15:8] = d[15:8];
		return v & m;
	endfunction : merge

	// inhibit period for the current settings
	function automatic logic [LFI_W-1:0] lfi_period(input logic en,
		input logic [1:0] sel);
		logic [LFI_W-1:0] p;
		p = P_LFI_STD_CYC;
		if (en) begin
			// fourth code is not defined, so standard timing stays [RULE2]
			if (sel == AN_SEL_50) p = P_LFI_50_CYC;
			else if (sel == AN_SEL_75) p = P_LFI_75_CYC;
			else if (sel == AN_SEL_150) p = P_LFI_150_CYC;
		end
		return p;
	endfunction : lfi_period

	////////////////////////////////////////////////////////////////////////
	// combinational helpers

	assign forced_100 = !an_enabled && speed_100;
	// extended duplex overrides only against a forced 100tx partner [RULE8]
	assign fd_res     = (s_r.ctl2[C2_EXT_FD] && partner_forced && speed_100
		&& (an_enabled || forced_100)) ? 1'b1 : std_full_duplex;
	assign do_write   = s_r.aw_got && s_r.w_got && !s_r.bvalid;

	// handshakes: one write and one read under way at a time
	assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
	assign s_axi_wready  = !s_r.w_got && !s_r.bvalid;
	assign s_axi_arready = !s_r.rvalid;

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_nxt = s_r;
		// capture address and data in either order
		if (s_axi_awvalid && s_axi_awready) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = s_axi_wdata;
			s_nxt.wstrb = s_axi_wstrb;
		end
		// commit a held write; control_two reserved bits written as given, control_one ones read zero [RULE15]
		if (do_write) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got  = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp  = RESP_OKAY;
			if (reg_sel(s_r.awaddr) == SEL_ONE) begin
				s_nxt.ctl1 = merge(s_r.ctl1, s_r.wdata, s_r.wstrb, C1_RW_MASK);
			end else if (reg_sel(s_r.awaddr) == SEL_TWO) begin
				s_nxt.ctl2 = merge(s_r.ctl2, s_r.wdata, s_r.wstrb, 16'hffff);
			end else begin
				s_nxt.bresp = RESP_SLVERR;
			end
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		// auto-mdix modes force fast parallel detect; set beats write [RULE7]
		if (s_r.ctl1[C1_FAST_MDIX] || s_r.ctl1[C1_ROBUST]) begin
			s_nxt.ctl2[C2_FAST_PD] = 1'b1;
		end
		// read path: answer one cycle after the address is taken
		if (s_axi_arvalid && s_axi_arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp  = RESP_OKAY;
			if (reg_sel(s_axi_araddr) == SEL_ONE) begin
				s_nxt.rdata = {16'h0000, s_r.ctl1};
			end else if (reg_sel(s_axi_araddr) == SEL_TWO) begin
				s_nxt.rdata = {16'h0000, s_r.ctl2};
			end else begin
				s_nxt.rdata = 32'h00000000;
				s_nxt.rresp = RESP_SLVERR;
			end
		end else if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end

		// inhibit timer, length picked when it starts [RULE1] [RULE2]
		s_nxt.lfi_expired = 1'b0;
		if (lfi_start) begin
			s_nxt.lfi_busy = 1'b1;
			s_nxt.lfi_cnt  = lfi_period(s_r.ctl1[C1_FAST_AN],
				s_r.ctl1[C1_AN_SEL_HI:C1_AN_SEL_LO]) - LFI_ONE;
		end else if (s_r.lfi_busy) begin
			if (s_r.lfi_cnt == '0) begin
				s_nxt.lfi_busy    = 1'b0;
				s_nxt.lfi_expired = 1'b1;
			end else begin
				s_nxt.lfi_cnt = s_r.lfi_cnt - LFI_ONE;
			end
		end

		// start-of-stream tracking
		s_nxt.rx_er_idle = 1'b0;
		if (sym_strobe) begin
			case (s_r.rx_st)
				RX_IDLE: begin
					if (sym_j) begin
						// fast mode raises rx_dv on /J/ alone [RULE4]
						s_nxt.rx_st = RX_GOT_J;
						s_nxt.rx_dv = s_r.ctl1[C1_FAST_RXDV];
					end else if (sym_err && s_r.ctl2[C2_IDLE_ERR]) begin
						// idle symbol errors only flagged when enabled [RULE12]
						s_nxt.rx_er_idle = 1'b1;
					end
				end
				RX_GOT_J: begin
					if (sym_k) begin
						// full /J/K/ seen: valid in either mode [RULE4]
						s_nxt.rx_st = RX_FRAME;
						s_nxt.rx_dv = 1'b1;
					end else begin
						// no /K/ after /J/: a fast assertion is withdrawn
						s_nxt.rx_st = RX_IDLE;
						s_nxt.rx_dv = 1'b0;
					end
				end
				default: begin
					if (sym_end) begin
						s_nxt.rx_st = RX_IDLE;
						s_nxt.rx_dv = 1'b0;
					end
				end
			endcase
		end

		// transmitter off on link loss in forced 100 [RULE5]
		s_nxt.tx_disable  = s_r.ctl2[C2_FAR_DROP] && forced_100 && !link_up;
		s_nxt.full_duplex = fd_res;
		// enhanced led: 100tx full duplex only, no blinking [RULE9] [RULE10]
		if (s_r.ctl2[C2_LED_ENH]) begin
			s_nxt.led_link = link_up && speed_100 && fd_res
				&& !s_r.ctl2[C2_FX_EN];
		end else begin
			s_nxt.led_link = link_up && !activity;
		end
		// isolate on half 100tx or any 10te link [RULE11]
		s_nxt.mii_isolate = s_r.ctl2[C2_ISOLATE] && link_up
			&& (!speed_100 || !fd_res);
		// pick the timing reference of the receive pair [RULE14]
		s_nxt.rmii_rxd = s_r.ctl2[C2_RMII_RXCLK] ? rmii_rxd_rec : rmii_rxd_ref;
	end

	////////////////////////////////////////////////////////////////////////
	// state register; the strap is caught while reset is held [RULE6]

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r                <= '0;
			s_r.rx_st          <= RX_IDLE;
			s_r.ctl1           <= C1_RESET;
			s_r.ctl2           <= C2_RESET;
			s_r.ctl2[C2_FX_EN] <= strap_fx;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transmit odd-nibble handling

	phylc_tx_odd u_tx_odd (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.odd_dis   (s_r.ctl2[C2_ODD_DIS]),
		.tx_tick   (tx_tick),
		.tx_en_in  (tx_en_in),
		.tx_er_in  (tx_er_in),
		.tx_en_out (tx_en_out),
		.tx_er_out (tx_er_out)
	);

	// outputs straight from the state register
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp  = s_r.bresp;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rdata  = s_r.rdata;
	assign s_axi_rresp  = s_r.rresp;
	assign fast_an      = s_r.ctl1[C1_FAST_AN];
	assign lfi_expired  = s_r.lfi_expired;
	assign rx_dv        = s_r.rx_dv;
	assign rx_er_idle   = s_r.rx_er_idle;
	assign tx_disable   = s_r.tx_disable;
	assign fx_mode      = s_r.ctl2[C2_FX_EN];
	assign fast_pd      = s_r.ctl2[C2_FAST_PD];
	assign full_duplex  = s_r.full_duplex;
	assign led_link     = s_r.led_link;
	assign mii_isolate  = s_r.mii_isolate;
	assign rmii_rxd     = s_r.rmii_rxd;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_lfi_fast50;
		(lfi_start && s_r.ctl1[C1_FAST_AN] && s_r.ctl1[C1_AN_SEL_HI:C1_AN_SEL_LO] == AN_SEL_50)
			|=> s_r.lfi_cnt == P_LFI_50_CYC - LFI_ONE;
	endproperty
	a_lfi_fast50: assert property (p_lfi_fast50) // [RULE2]
		else $error("fast 50 ms period not loaded");

	property p_lfi_std;
		(lfi_start && !s_r.ctl1[C1_FAST_AN]) |=> s_r.lfi_cnt == P_LFI_STD_CYC - LFI_ONE;
	endproperty
	a_lfi_std: assert property (p_lfi_std) // [RULE1]
		else $error("standard period not loaded");

	property p_rxdv_fast;
		(sym_strobe && sym_j && s_r.rx_st == RX_IDLE && s_r.ctl1[C1_FAST_RXDV])
			|=> rx_dv;
	endproperty
	a_rxdv_fast: assert property (p_rxdv_fast) // [RULE4]
		else $error("rx_dv not raised on /J/ in fast mode");

	property p_rxdv_norm;
		(sym_strobe && sym_j && s_r.rx_st == RX_IDLE && !s_r.ctl1[C1_FAST_RXDV])
			|=> !rx_dv;
	endproperty
	a_rxdv_norm: assert property (p_rxdv_norm) // [RULE4]
		else $error("rx_dv raised early in normal mode");

	property p_far_drop;
		(s_r.ctl2[C2_FAR_DROP] && !an_enabled && speed_100 && !link_up)
			|=> tx_disable;
	endproperty
	a_far_drop: assert property (p_far_drop) // [RULE5]
		else $error("transmitter not disabled on link loss");

	property p_fast_pd;
		(s_r.ctl1[C1_FAST_MDIX] || s_r.ctl1[C1_ROBUST]) |=> ##1 fast_pd;
	endproperty
	a_fast_pd: assert property (p_fast_pd) // [RULE7]
		else $error("fast parallel detect not forced");

	property p_led_enh;
		(s_r.ctl2[C2_LED_ENH] && $stable(s_r.ctl2) && (!speed_100 || !link_up))
			|=> !led_link;
	endproperty
	a_led_enh: assert property (p_led_enh) // [RULE9]
		else $error("enhanced led lit without 100tx link");

	property p_isolate;
		(s_r.ctl2[C2_ISOLATE] && link_up && !speed_100) |=> mii_isolate;
	endproperty
	a_isolate: assert property (p_isolate) // [RULE11]
		else $error("mii not isolated on 10te link");

	property p_idle_err_off;
		!s_r.ctl2[C2_IDLE_ERR] |=> !rx_er_idle;
	endproperty
	a_idle_err_off: assert property (p_idle_err_off) // [RULE12]
		else $error("idle error flagged while disabled");

	property p_rmii_sel;
		s_r.ctl2[C2_RMII_RXCLK] |=> rmii_rxd == $past(rmii_rxd_rec);
	endproperty
	a_rmii_sel: assert property (p_rmii_sel) // [RULE14]
		else $error("rmii pair not taken from recovered clock");

	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read:  cover property (s_axi_rvalid && s_axi_rready);
	c_frame: cover property (s_r.rx_st == RX_GOT_J ##[1:20] s_r.rx_st == RX_FRAME);

endmodule : phylc_top

// >>> src/phylc_pkg.sv
// phylc_pkg: constants and types shared by the phy link control block
// assumes a single 125 MHz clock and a 32-bit axi4-lite register port
package phylc_pkg;

	// clock and bus widths
	localparam int CLK_KHZ = 125000;           // 125 MHz expressed in kHz
	localparam int ADDR_W  = 8;                // axi byte address width
	localparam int DATA_W  = 32;               // axi data width
	localparam int REG_W   = 16;               // documented register width

	// register indices as printed; byte address is four times the index
	localparam logic [ADDR_W-1:0] IDX_CONTROL_ONE = 8'h09;
	localparam logic [ADDR_W-1:0] IDX_CONTROL_TWO = 8'h0a;
	localparam logic [ADDR_W-1:0] ADR_CONTROL_ONE = ADDR_W'(IDX_CONTROL_ONE * 4);
	localparam logic [ADDR_W-1:0] ADR_CONTROL_TWO = ADDR_W'(IDX_CONTROL_TWO * 4);

	// control_one fields
	localparam int C1_FAST_MDIX  = 6;          // fast auto-mdix
	localparam int C1_ROBUST     = 5;          // robust auto-mdix
	localparam int C1_FAST_AN    = 4;          // fast auto-negotiation enable
	localparam int C1_AN_SEL_HI  = 3;          // fast an select, high bit
	localparam int C1_AN_SEL_LO  = 2;          // fast an select, low bit
	localparam int C1_FAST_RXDV  = 1;          // fast rx_dv detection
	localparam logic [REG_W-1:0] C1_RESET   = 16'h0000;
	localparam logic [REG_W-1:0] C1_RW_MASK = 16'h03fe; // 15:10 and 0 read zero

	// control_two fields
	localparam int C2_FAR_DROP   = 15;         // force far-end link drop
	localparam int C2_FX_EN      = 14;         // 100base-fx enable (strap)
	localparam int C2_FAST_PD    = 6;          // fast link-up in parallel detect
	localparam int C2_EXT_FD     = 5;          // extended full duplex
	localparam int C2_LED_ENH    = 4;          // enhanced link led
	localparam int C2_ISOLATE    = 3;          // isolate mii
	localparam int C2_IDLE_ERR   = 2;          // rx_er during idle
	localparam int C2_ODD_DIS    = 1;          // odd-nibble detection disable
	localparam int C2_RMII_RXCLK = 0;          // rmii receive clock select
	localparam logic [REG_W-1:0] C2_RESET   = 16'h0100; // reserved 13:7 = 0000010

	// fast auto-negotiation select codes
	localparam logic [1:0] AN_SEL_50  = 2'h0;
	localparam logic [1:0] AN_SEL_75  = 2'h1;
	localparam logic [1:0] AN_SEL_150 = 2'h2;

	// link fail inhibit times in ms and derived cycle counts
	localparam int LFI_W       = 27;
	localparam int LFI_50_MS   = 50;
	localparam int LFI_75_MS   = 75;
	localparam int LFI_150_MS  = 150;
	localparam int LFI_STD_MS  = 750;          // plain default for standard timing
	localparam logic [LFI_W-1:0] LFI_50_CYC  = LFI_W'(LFI_50_MS * CLK_KHZ);
	localparam logic [LFI_W-1:0] LFI_75_CYC  = LFI_W'(LFI_75_MS * CLK_KHZ);
	localparam logic [LFI_W-1:0] LFI_150_CYC = LFI_W'(LFI_150_MS * CLK_KHZ);
	localparam logic [LFI_W-1:0] LFI_STD_CYC = LFI_W'(LFI_STD_MS * CLK_KHZ);
	localparam logic [LFI_W-1:0] LFI_ONE     = 27'h0000001;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// register select result of address decode
	typedef enum logic [1:0] {SEL_NONE, SEL_ONE, SEL_TWO} phylc_sel_e;

	// start-of-stream tracking for rx_dv
	typedef enum logic [1:0] {RX_IDLE, RX_GOT_J, RX_FRAME} phylc_rx_e;

endpackage : phylc_pkg

// >>> src/phylc_tx_odd.sv
// phylc_tx_odd: stretches tx_en by one tx_clk cycle when a frame ends on an
// odd nibble, and marks that extra cycle as a transmit error
// assumes tx_tick pulses once per tx_clk cycle, synchronous to aclk
`timescale 1ns/1ps
module phylc_tx_odd
	import phylc_pkg::*;
(
	input  wire logic aclk,         // system clock
	input  wire logic aresetn,      // synchronous reset, active low
	input  wire logic odd_dis,      // 1 disables odd-nibble detection
	input  wire logic tx_tick,      // one pulse per tx_clk cycle
	input  wire logic tx_en_in,     // tx enable from the mac
	input  wire logic tx_er_in,     // tx error from the mac
	output logic      tx_en_out,    // tx enable toward the coder
	output logic      tx_er_out     // tx error toward the coder
);

	// all state of this module
	typedef struct packed {
		logic odd;                  // nibble count parity in this frame
		logic en;                   // registered tx enable
		logic er;                   // registered tx error
	} phylc_tx_s;

	phylc_tx_s s_r;                 // current state
	phylc_tx_s s_nxt;               // next state

	// next-state logic; only moves on a tx_clk tick
	always_comb begin
		s_nxt = s_r;
		if (tx_tick) begin
			if (tx_en_in) begin
				// count nibbles of the frame
				s_nxt.odd = ~s_r.odd;
				s_nxt.en  = 1'b1;
				s_nxt.er  = tx_er_in;
			end else if (s_r.odd && s_r.en && !odd_dis) begin
				// frame ended odd: one extra cycle flagged as error [RULE13]
				s_nxt.odd = 1'b0;
				s_nxt.en  = 1'b1;
				s_nxt.er  = 1'b1;
			end else begin
				s_nxt.odd = 1'b0;
				s_nxt.en  = 1'b0;
				s_nxt.er  = 1'b0;
			end
		end
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tx_en_out = s_r.en;
	assign tx_er_out = s_r.er;

	// odd ending with detection on gives exactly one flagged extra cycle
	property p_odd_extend;
		@(posedge aclk) disable iff (!aresetn)
		(tx_tick && !tx_en_in && s_r.odd && s_r.en && !odd_dis)
			|=> (tx_en_out && tx_er_out);
	endproperty
	a_odd_extend: assert property (p_odd_extend) // [RULE13]
		else $error("odd nibble end not extended");

	// with detection off no extra cycle follows the frame
	property p_odd_off;
		@(posedge aclk) disable iff (!aresetn)
		(tx_tick && !tx_en_in && odd_dis) |=> !tx_en_out;
	endproperty
	a_odd_off: assert property (p_odd_off) // [RULE13]
		else $error("tx_en extended with detection disabled");

	c_odd_extend: cover property (@(posedge aclk) disable iff (!aresetn)
		tx_en_out && tx_er_out && !tx_er_in);

endmodule : phylc_tx_odd

// >>> tb/phylc_mac_model.sv
// phylc_mac_model: mac side of the mii transmit path, sends whole-nibble frames
// assumes one tx_clk cycle lasts five aclk cycles
`timescale 1ns/1ps
module phylc_mac_model (
	input  wire logic       aclk,    // system clock
	input  wire logic       aresetn, // sync reset, active low
	input  wire logic       go,      // start a frame
	input  wire logic [3:0] nib,     // nibbles in the frame
	output logic            tx_tick, // one pulse per tx_clk cycle
	output logic            tx_en,   // frame enable
	output logic            tx_er    // this mac never flags errors
);
	logic [2:0] div_r;  // tx_clk divider
	logic [3:0] left_r; // nibbles still to send
	assign tx_tick = (div_r == 3'h4);
	assign tx_er = 1'b0;
	// enable moves only on tick edges, as a real tx_clk source would
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_r <= 3'h0;
			left_r <= 4'h0;
			tx_en <= 1'b0;
		end else begin
			div_r <= tx_tick ? 3'h0 : div_r + 3'h1;
			if (go) begin
				left_r <= nib;
			end else if (tx_tick) begin
				tx_en <= (left_r != 4'h0);
				left_r <= (left_r != 4'h0) ? left_r - 4'h1 : 4'h0;
			end
		end
	end
endmodule : phylc_mac_model

// >>> tb/phy_link_control_registers_test.sv
// phy_link_control_registers_test: self-checking bench for phylc_top
// assumes phylc_mac_model on the transmit side; inhibit counts shortened
`timescale 1ns/1ps
module phy_link_control_registers_test;
	import phylc_pkg::*;
	logic aclk = 0, aresetn = 0, go = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, tx_tick, tx_en_in, tx_er_in, fast_an, lfi_expired;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb = 4'hf, nib = 0;
	logic [1:0] s_axi_bresp, s_axi_rresp, rmii_rxd_rec = 0, rmii_rxd_ref = 0, rmii_rxd;
	logic strap_fx = 1, link_up = 0, speed_100 = 0, std_full_duplex = 0, an_enabled = 0;
	logic partner_forced = 0, activity = 0, lfi_start = 0, sym_strobe = 0, sym_j = 0, sym_k = 0;
	logic sym_end = 0, sym_err = 0, rx_dv, rx_er_idle, tx_disable, fx_mode, fast_pd;
	logic full_duplex, led_link, mii_isolate, tx_en_out, tx_er_out, fd, seen, od;
	logic [15:0] c1, e2;
	int failures = 0, samples_checked = 0, en_n = 0, er_n = 0, n, s, i, a, b;
	phylc_top #(.P_LFI_50_CYC(27'h14), .P_LFI_75_CYC(27'h1e), .P_LFI_150_CYC(27'h3c),
		.P_LFI_STD_CYC(27'h12c)) phylc_top_i (.*);
	phylc_mac_model phylc_mac_model_i (.aclk, .aresetn, .go, .nib, .tx_tick,
		.tx_en(tx_en_in), .tx_er(tx_er_in));
	always #4 aclk = ~aclk;
	// cycles of coder enable and error seen
	always @(posedge aclk) begin
		en_n <= en_n + int'(tx_en_out === 1'b1);
		er_n <= er_n + int'(tx_er_out === 1'b1);
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	task automatic tmo(input int k);
		if (k >= 50) begin
			failures++;
			end_sim();
		end
	endtask : tmo
	// axi write: both channels offered together, each dropped once taken
	task automatic wr(input logic [7:0] ad, input logic [15:0] d, input logic [1:0] e);
		int k;
		@(posedge aclk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= {16'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (k = 0; k < 50 && s_axi_bvalid !== 1'b1; k++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		tmo(k);
		chk(s_axi_bresp, e);
	endtask : wr
	task automatic rd(input logic [7:0] ad, input logic [1:0] e);
		int k;
		@(posedge aclk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (k = 0; k < 50 && s_axi_rvalid !== 1'b1; k++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		tmo(k);
		rv = s_axi_rdata;
		chk(s_axi_rresp, e);
	endtask : rd
	// one strobed symbol; returns at the edge where its effect is visible
	task automatic sym(input logic j, k, e, r);
		@(posedge aclk);
		sym_strobe <= 1'b1;
		{sym_j, sym_k, sym_end, sym_err} <= {j, k, e, r};
		@(posedge aclk);
		sym_strobe <= 1'b0;
		@(posedge aclk);
	endtask : sym
	function automatic int exp_lfi(input int c);
		return (c == 0) ? 20 : (c == 1) ? 30 : (c == 2) ? 60 : 300;
	endfunction : exp_lfi
	initial begin
		void'($urandom(32'h1a60));
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ADR_CONTROL_ONE, RESP_OKAY);
		chk(rv, 32'h0);
		rd(ADR_CONTROL_TWO, RESP_OKAY);
		chk(rv, 32'h4100);
		wr(8'h2c, 16'hffff, RESP_SLVERR);
		rd(8'h2c, RESP_SLVERR);
		chk(rv, 32'h0);
		$display("reset and decode test done");
		for (i = 0; i < 6; i++) begin
			c1 = 16'($urandom);
			e2 = (16'($urandom) & 16'hc07f) | 16'h0100; // reserved kept at reset
			wr(ADR_CONTROL_ONE, c1, RESP_OKAY);
			wr(ADR_CONTROL_TWO, e2, RESP_OKAY);
			e2[6] = e2[6] | c1[6] | c1[5];
			rd(ADR_CONTROL_ONE, RESP_OKAY);
			chk(rv, {16'h0, c1 & C1_RW_MASK});
			rd(ADR_CONTROL_TWO, RESP_OKAY);
			chk(rv, {16'h0, e2});
			chk(fast_pd, e2[6]);
			for (s = 0; s < 8; s++) begin
				@(posedge aclk);
				{link_up, speed_100, std_full_duplex, an_enabled, partner_forced, activity} <= 6'($urandom);
				{rmii_rxd_rec, rmii_rxd_ref} <= 4'($urandom);
				repeat (2) @(posedge aclk);
				fd = std_full_duplex | (e2[5] & speed_100 & partner_forced);
				chk(full_duplex, fd);
				chk(led_link, e2[4] ? link_up & speed_100 & fd & !e2[14]
					: link_up & !activity);
				chk(mii_isolate, e2[3] & link_up & (!speed_100 | !fd));
				chk(tx_disable, e2[15] & !an_enabled & speed_100 & !link_up);
				chk(rmii_rxd, e2[0] ? rmii_rxd_rec : rmii_rxd_ref);
				chk(fx_mode, e2[14]);
			end
		end
		$display("register and status test done");
		for (s = 0; s < 5; s++) begin
			wr(ADR_CONTROL_ONE, (s < 4) ? {11'h0, 1'b1, 2'(s), 2'h0} : 16'h0, RESP_OKAY);
			@(posedge aclk);
			lfi_start <= 1'b1;
			@(posedge aclk);
			lfi_start <= 1'b0;
			for (n = 0; n < 400 && lfi_expired !== 1'b1; n++) @(posedge aclk);
			tmo(n / 8);
			chk(n, exp_lfi(s) + 1); // pulse one edge after the count ends
			chk(fast_an, s < 4);
		end
		$display("inhibit timer test done");
		for (s = 0; s < 2; s++) begin
			wr(ADR_CONTROL_ONE, {14'h0, 1'(s), 1'b0}, RESP_OKAY);
			wr(ADR_CONTROL_TWO, {13'h20, 1'(s), 2'h0}, RESP_OKAY);
			sym(0, 0, 0, 1);
			chk(rx_er_idle, s);
			sym(1, 0, 0, 0);
			chk(rx_dv, s);
			sym(0, 1, 0, 0);
			chk(rx_dv, 1);
			sym(0, 0, 1, 0);
			chk(rx_dv, 0);
		end
		$display("receive test done");
		for (s = 0; s < 3; s++) begin
			wr(ADR_CONTROL_TWO, {13'h20, 1'b0, 1'(s == 2), 1'b0}, RESP_OKAY);
			@(posedge aclk);
			go <= 1'b1;
			nib <= (s == 1) ? 4'h4 : 4'h3;
			a = en_n;
			b = er_n;
			@(posedge aclk);
			go <= 1'b0;
			seen = 0;
			for (n = 0; n < 100 && !(seen && tx_en_out === 1'b0); n++) begin
				@(posedge aclk);
				seen = seen | (tx_en_out === 1'b1);
			end
			tmo(n / 2);
			od = nib[0] & (s != 2);
			chk(en_n - a, 5 * (nib + od));
			chk(er_n - b, 5 * od);
		end
		$display("transmit test done");
		end_sim();
	end
endmodule : phy_link_control_registers_test
